/* File: hw/cbh_config_tail.sv */
// Configuration header tail: header type, self-test, window base and capability pointer.
//
// Behaviour
// - The header-type byte at 0Eh is read-only in both functions and reads 82h.
// - Offsets 0 to 7Fh hold the standard header and 80h to FFh are flagged as extension space.
// - The self-test byte at 0Fh is read-only, reads 00h, and writes to it do nothing.
// - Base bits 31 to 12 are writable so the window sits on any 4 KiB boundary.
// - Base bits 11 to 0 ignore writes and read zero.
// - Writing all ones to the base reads back FFFF F000h.
// - The window decodes socket registers from offset 000h and legacy registers from 800h.
// - Each function owns a separate base register.
// - The base register resets to zero.
// - The capability pointer at 14h is read-only and reads A0h.
`timescale 1ns/10ps
`default_nettype none
module cbh_config_tail #(
   parameter int FUNCS = cbh_pkg::FUNC_COUNT
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Configuration access, one doubleword per request.
   input wire logic cfg_func,
   input wire logic [5:0] cfg_dw_addr,
   input wire logic [3:0] cfg_be,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   output logic cfg_ext_sel,
   // Memory window decode, per function.
   input wire logic [1:0] mem_en,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic [1:0] mem_hit_sock,
   output logic [1:0] mem_hit_legacy,
   output logic [21:0] mem_win_offset
);
   logic [1:0][19:0] base_r;

   // Merges write data into an old value under the byte enables.
   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   wire sel_hdr = cfg_dw_addr == cbh_pkg::OFS_HDR_TYPE[7:2];
   wire sel_base = cfg_dw_addr == cbh_pkg::OFS_WIN_BASE[7:2];
   wire sel_cap = cfg_dw_addr == cbh_pkg::OFS_CAP_PTR[7:2];
   wire [19:0] base_cur = base_r[cfg_func];
   wire [31:0] hdr_word = {cbh_pkg::SELF_TEST_VAL, cbh_pkg::HDR_TYPE_VAL, 16'h0000};
   wire [31:0] cap_word = {24'h000000, cbh_pkg::CAP_PTR_VAL};
   wire [31:0] base_word = {base_cur, 12'h000};
   wire [31:0] rd_word = sel_base ? base_word : sel_hdr ? hdr_word : sel_cap ? cap_word : 32'h0;
   wire [31:0] base_merged = merge_be(base_word, cfg_wdata, cfg_be);

   assign cfg_ext_sel = cfg_dw_addr >= cbh_pkg::OFS_EXT_FIRST[7:2];

   // Only the base register holds state; all other writes fall away.
   genvar f;
   generate
      for (f = 0; f < FUNCS; f++) begin : g_func
         wire wr_here = cfg_wr && sel_base && (cfg_func == 1'(f));
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               base_r[f] <= cbh_pkg::BASE_RST;
            end else if (wr_here) begin
               base_r[f] <= base_merged[31:cbh_pkg::BASE_LSB];
            end
         end
         cbh_window_decode u_dec (
            .core_clk(core_clk),
            .rstn(rstn),
            .base(base_r[f]),
            .win_en(mem_en[f]),
            .mem_req(mem_req),
            .mem_addr(mem_addr),
            .hit_sock(mem_hit_sock[f]),
            .hit_legacy(mem_hit_legacy[f]),
            .win_offset(mem_win_offset[f*11 +: 11])
         );
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata <= 32'h00000000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
         cfg_rdata <= cfg_rd ? rd_word : 32'h00000000;
      end
   end

   hdr_type_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_hdr) |=> cfg_rvalid && cfg_rdata[23:16] == 8'h82)
      else $error("header type byte not 82h");
   self_test_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_hdr) |=> cfg_rdata[31:24] == 8'h00)
      else $error("self-test byte not zero");
   cap_ptr_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_cap) |=> cfg_rdata == 32'h000000A0)
      else $error("capability pointer not A0h");
   ext_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cfg_ext_sel == cfg_dw_addr[5])
      else $error("extension area flag wrong");
   base_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_base) |=> cfg_rdata[11:0] == 12'h000)
      else $error("base low bits not zero");
   base_ones_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be == 4'hF && cfg_wdata == 32'hFFFFFFFF && !cfg_func)
      ##1 (cfg_rd && sel_base && !cfg_func) |=> cfg_rdata == 32'hFFFFF000)
      else $error("all-ones write did not read FFFF F000h");
   base_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be == 4'hF) |=> base_r[$past(cfg_func)] == $past(cfg_wdata[31:12]))
      else $error("base upper bits not written");
   func_split_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && !cfg_func) |=> $stable(base_r[1]))
      else $error("function 0 write touched function 1 base");
   base_reset_a: assert property (@(posedge core_clk)
      $rose(rstn) |-> base_r[0] == 20'h00000 && base_r[1] == 20'h00000)
      else $error("base not zero after reset");
   ro_drop_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && !sel_base) |=> $stable(base_r))
      else $error("write outside base changed state");

   // Read answer timing and lane placement.
   rd_valid_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cfg_rd |=> cfg_rvalid)
      else $error("read not answered in the next cycle");
   rd_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h00000000)
      else $error("read data not idle without a read");
   hdr_lanes_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_hdr) |=> cfg_rdata[15:0] == 16'h0000)
      else $error("lower header lanes not zero");
   unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && !sel_hdr && !sel_base && !sel_cap) |=> cfg_rdata == 32'h00000000)
      else $error("unmapped doubleword not zero");
   base_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && sel_base) |=> cfg_rdata[31:12] == $past(base_cur))
      else $error("base read does not match stored base");
   ext_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sel_base |-> !cfg_ext_sel)
      else $error("base doubleword flagged as extension space");
   ext_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_rd && cfg_ext_sel) |=> cfg_rdata == 32'h00000000)
      else $error("extension space read not zero");

   // Each byte lane of the base moves only under its own enable.
   lane3_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be[3])
      |=> base_r[$past(cfg_func)][19:12] == $past(cfg_wdata[31:24]))
      else $error("base lane 3 not written");
   lane2_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be[2])
      |=> base_r[$past(cfg_func)][11:4] == $past(cfg_wdata[23:16]))
      else $error("base lane 2 not written");
   lane1_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be[1])
      |=> base_r[$past(cfg_func)][3:0] == $past(cfg_wdata[15:12]))
      else $error("base lane 1 not written");
   lane3_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && !cfg_be[3])
      |=> base_r[$past(cfg_func)][19:12] == $past(base_cur[19:12]))
      else $error("base lane 3 changed without its enable");
   lane2_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && !cfg_be[2])
      |=> base_r[$past(cfg_func)][11:4] == $past(base_cur[11:4]))
      else $error("base lane 2 changed without its enable");
   lane1_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && !cfg_be[1])
      |=> base_r[$past(cfg_func)][3:0] == $past(base_cur[3:0]))
      else $error("base lane 1 changed without its enable");
   lane0_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && sel_base && cfg_be == 4'h1) |=> $stable(base_r))
      else $error("lane 0 write changed the base");
   func1_split_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (cfg_wr && cfg_func) |=> $stable(base_r[0]))
      else $error("function 1 write touched function 0 base");
   base_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !cfg_wr |=> $stable(base_r))
      else $error("base changed without a write");
   rst_idle_a: assert property (@(posedge core_clk)
      $rose(rstn) |-> !cfg_rvalid && cfg_rdata == 32'h00000000 &&
         mem_hit_sock == 2'b00 && mem_hit_legacy == 2'b00)
      else $error("outputs not idle after reset");

   // Window decode seen at the ports of both functions.
   win_offset_a: assert property (@(posedge core_clk) disable iff (!rstn)
      1'b1 |=> mem_win_offset == {2{$past(mem_addr[10:0])}})
      else $error("window offset does not follow the address");
   idle_miss_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !mem_req |=> mem_hit_sock == 2'b00 && mem_hit_legacy == 2'b00)
      else $error("window hit without a request");
   off_miss_a: assert property (@(posedge core_clk) disable iff (!rstn)
      1'b1 |=> ((mem_hit_sock | mem_hit_legacy) & ~$past(mem_en)) == 2'b00)
      else $error("disabled window reported a hit");
   win0_hit_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (mem_req && mem_en[0] && mem_addr[31:cbh_pkg::BASE_LSB] == base_r[0])
      |=> mem_hit_sock[0] == !$past(mem_addr[cbh_pkg::LEGACY_BIT]) &&
         mem_hit_legacy[0] == $past(mem_addr[cbh_pkg::LEGACY_BIT]))
      else $error("function 0 window hit decoded wrongly");
   win1_hit_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (mem_req && mem_en[1] && mem_addr[31:cbh_pkg::BASE_LSB] == base_r[1])
      |=> mem_hit_sock[1] == !$past(mem_addr[cbh_pkg::LEGACY_BIT]) &&
         mem_hit_legacy[1] == $past(mem_addr[cbh_pkg::LEGACY_BIT]))
      else $error("function 1 window hit decoded wrongly");
   base0_miss_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (mem_req && mem_addr[31:cbh_pkg::BASE_LSB] != base_r[0]) |=> !mem_hit_sock[0] && !mem_hit_legacy[0])
      else $error("function 0 hit outside its window");
   base1_miss_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (mem_req && mem_addr[31:cbh_pkg::BASE_LSB] != base_r[1]) |=> !mem_hit_sock[1] && !mem_hit_legacy[1])
      else $error("function 1 hit outside its window");
   win_split_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (mem_req && mem_en == 2'b11 && base_r[0] != base_r[1])
      |=> !((mem_hit_sock[0] || mem_hit_legacy[0]) && (mem_hit_sock[1] || mem_hit_legacy[1])))
      else $error("both windows hit with different bases");
endmodule
`default_nettype wire

/* File: hw/cbh_pkg.sv */
// Shared constants for the bridge configuration header tail.
`default_nettype none
package cbh_pkg;
   localparam int FUNC_COUNT = 2;
   localparam logic [7:0] OFS_HDR_TYPE = 8'h0E;
   localparam logic [7:0] OFS_SELF_TEST = 8'h0F;
   localparam logic [7:0] OFS_WIN_BASE = 8'h10;
   localparam logic [7:0] OFS_CAP_PTR = 8'h14;
   localparam logic [7:0] OFS_EXT_FIRST = 8'h80;
   localparam logic [7:0] HDR_TYPE_VAL = 8'h82;
   localparam logic [7:0] SELF_TEST_VAL = 8'h00;
   localparam logic [7:0] CAP_PTR_VAL = 8'hA0;
   localparam int BASE_LSB = 12;
   localparam int BASE_W = 20;
   localparam logic [19:0] BASE_RST = 20'h00000;
   localparam int LEGACY_BIT = 11;
   localparam int WIN_OFS_W = 11;
endpackage
`default_nettype wire

/* File: hw/cbh_window_decode.sv */
// Memory window decoder for one socket function.
`timescale 1ns/10ps
`default_nettype none
module cbh_window_decode (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Window placement.
   input wire logic [19:0] base,
   input wire logic win_en,
   // Memory request.
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   // Decode result.
   output logic hit_sock,
   output logic hit_legacy,
   output logic [10:0] win_offset
);
   wire in_window = mem_req && win_en && (mem_addr[31:cbh_pkg::BASE_LSB] == base);
   wire legacy_half = mem_addr[cbh_pkg::LEGACY_BIT];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hit_sock <= 1'b0;
         hit_legacy <= 1'b0;
         win_offset <= 11'h000;
      end else begin
         hit_sock <= in_window && !legacy_half;
         hit_legacy <= in_window && legacy_half;
         win_offset <= mem_addr[cbh_pkg::WIN_OFS_W-1:0];
      end
   end

   // The lower half of the window holds socket registers, the upper the legacy set.
   sock_half_a: assert property (@(posedge core_clk) disable iff (!rstn)
      hit_sock |-> $past(mem_addr[cbh_pkg::LEGACY_BIT]) == 1'b0 && $past(in_window))
      else $error("socket hit outside the lower window half");
   legacy_half_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (in_window && legacy_half) |=> hit_legacy && !hit_sock)
      else $error("legacy half of window not decoded");
endmodule
`default_nettype wire

/* File: tb/cbh_config_tail_tb.sv */
// Self-checking bench for the configuration header tail.
`timescale 1ns/10ps
`default_nettype none
module cbh_config_tail_tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic cfg_func = 1'b0;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic mem_req = 1'b0;
   logic [5:0] cfg_dw_addr = 6'h00;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] mem_addr = 32'h0;
   logic [1:0] mem_en = 2'h3;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid;
   logic cfg_ext_sel;
   logic [1:0] mem_hit_sock;
   logic [1:0] mem_hit_legacy;
   logic [21:0] mem_win_offset;
   logic [31:0] base_m [2] = '{32'h0, 32'h0};
   logic [31:0] r;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   integer seed = 32'h0000BD06;
   cbh_config_tail cbh_config_tail_i (.core_clk, .rstn, .cfg_func, .cfg_dw_addr, .cfg_be,
      .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_ext_sel, .mem_en, .mem_req,
      .mem_addr, .mem_hit_sock, .mem_hit_legacy, .mem_win_offset);
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] exp_rd(input logic f, input logic [5:0] a);
      case (a)
         6'h03: return {cbh_pkg::SELF_TEST_VAL, cbh_pkg::HDR_TYPE_VAL, 16'h0000};
         6'h04: return base_m[f];
         6'h05: return {24'h000000, cbh_pkg::CAP_PTR_VAL};
         default: return 32'h0;
      endcase
   endfunction
   task automatic cfg_write(input logic f, input logic [5:0] a, input logic [3:0] be,
                            input logic [31:0] d);
      @(negedge core_clk);
      {cfg_func, cfg_dw_addr, cfg_be, cfg_wdata, cfg_wr} = {f, a, be, d, 1'b1};
      @(negedge core_clk);
      cfg_wr = 1'b0;
      for (int i = 0; i < 4; i++) if (a == 6'h04 && be[i]) base_m[f][8*i+:8] = d[8*i+:8];
      base_m[f] = base_m[f] & 32'hFFFFF000;
   endtask
   task automatic cfg_read(input logic f, input logic [5:0] a);
      @(negedge core_clk);
      {cfg_func, cfg_dw_addr, cfg_rd} = {f, a, 1'b1};
      @(negedge core_clk);
      cfg_rd = 1'b0;
      chk({31'h0, cfg_rvalid}, 32'h1);
      chk(cfg_rdata, exp_rd(f, a));
   endtask
   task automatic mem_chk(input logic [31:0] a);
      logic [1:0] hit;
      for (int i = 0; i < 2; i++) hit[i] = mem_en[i] && a[31:12] == base_m[i][31:12];
      @(negedge core_clk);
      {mem_req, mem_addr} = {1'b1, a};
      @(negedge core_clk);
      mem_req = 1'b0;
      chk({28'h0, mem_hit_sock, mem_hit_legacy},
          {28'h0, hit & ~{2{a[11]}}, hit & {2{a[11]}}});
      chk({10'h0, mem_win_offset}, {10'h0, a[10:0], a[10:0]});
      chk({31'h0, cfg_rvalid}, 32'h0);
      chk(cfg_rdata, 32'h0);
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      for (int f = 0; f < 2; f++) for (int a = 2; a < 7; a++) cfg_read(1'(f), 6'(a));
      cfg_write(1'b0, 6'h03, 4'hF, 32'hFFFFFFFF);
      cfg_write(1'b1, 6'h05, 4'hF, 32'hFFFFFFFF);
      // Write all ones and read back in the very next cycle.
      @(negedge core_clk);
      {cfg_func, cfg_dw_addr, cfg_be, cfg_wdata} = {1'b0, 6'h04, 4'hF, 32'hFFFFFFFF};
      cfg_wr = 1'b1;
      @(negedge core_clk);
      {cfg_wr, cfg_rd} = 2'b01;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      base_m[0] = 32'hFFFFF000;
      chk({31'h0, cfg_rvalid}, 32'h1);
      chk(cfg_rdata, 32'hFFFFF000);
      cfg_write(1'b0, 6'h04, 4'hF, 32'hFFFFFFFF);
      for (int a = 3; a < 6; a++) cfg_read(1'b0, 6'(a));
      cfg_write(1'b1, 6'h04, 4'h1, 32'hFFFFFFFF);
      cfg_read(1'b1, 6'h04);
      repeat (60) begin
         r = $random(seed);
         cfg_write(r[0], 6'h03 + {4'h0, r[2:1]}, r[6:3], $random(seed));
         cfg_read(r[0], 6'h03 + {4'h0, r[8:7]});
         mem_en = r[10:9];
         mem_chk({base_m[r[11]][31:12], r[23:12]});
         mem_chk($random(seed));
      end
      mem_en = 2'h3;
      mem_chk(base_m[0] | 32'h000007FF);
      mem_chk(base_m[0] | 32'h00000800);
      for (int a = 31; a < 34; a++) begin
         @(negedge core_clk);
         cfg_dw_addr = 6'(a);
         #1 chk({31'h0, cfg_ext_sel}, {31'h0, a >= 32});
      end
      cfg_read(1'b0, 6'h20);
      @(negedge core_clk);
      rstn = 1'b0;
      @(negedge core_clk);
      rstn = 1'b1;
      base_m = '{32'h0, 32'h0};
      cfg_read(1'b0, 6'h04);
      cfg_read(1'b1, 6'h04);
      close_out();
   end
endmodule
`default_nettype wire
